// *** src/ccp_pkg.sv ***
package ccp_pkg;

  // ****************************************
  // Register map (word index, byte = 4*index)
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 4;
  // Per channel: control at 2*ch, data at 2*ch+1
  localparam logic [ADDR_W-1:0] CTRL_BASE_IDX = 4'h0;
  localparam logic [ADDR_W-1:0] TSEL_IDX = 4'h8;
  localparam logic [ADDR_W-1:0] FLAG_IDX = 4'h9;
  localparam logic [ADDR_W-1:0] MSGSEL_IDX = 4'ha;

  // ****************************************
  // Control register layout
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int DUTY_LOW_LSB = 4;
  localparam int DUTY_LOW_W = 2;
  localparam int CTRL_W = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int TSEL_W = 2;
  localparam int NUM_TIMERS = 4;

  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET_HI = 4'h8;
  localparam logic [3:0] MODE_CMP_SET_LO = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  localparam int PRESCALE_4 = 4;
  localparam int PRESCALE_16 = 16;
  localparam int PWM_W = 10;

endpackage

// *** src/ccp_channel.sv ***
`timescale 1ns/10ps
module ccp_channel #(
  parameter int TIMER_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Configuration
  input wire logic [3:0] mode_i,
  input wire logic [1:0] duty_low_bits_i,
  input wire logic [TIMER_W-1:0] data_wr_i,
  input wire logic data_we_i,
  input wire logic flag_clr_i,
  // Capture source, timer
  input wire logic src_sync_i,
  input wire logic msg_sel_i,
  input wire logic msg_evt_i,
  input wire logic [TIMER_W-1:0] timer_i,
  input wire logic [ccp_pkg::PWM_W-1:0] pwm_cnt_i,
  // Results
  output logic [TIMER_W-1:0] data_o,
  output logic flag_o,
  output logic pin_o,
  output logic pin_oe_o,
  output logic trig_o
);

  logic [TIMER_W-1:0] data_r;
  logic flag_r;
  logic pin_r;
  logic pin_oe_r;
  logic trig_r;
  logic src_d_r;
  logic [3:0] pre_r;
  logic [3:0] mode_d_r;
  logic rise;
  logic fall;
  logic edge_evt;
  logic cap_evt;
  logic match;
  logic is_cmp;
  logic pwm_mode;
  logic [ccp_pkg::PWM_W-1:0] duty;
  logic entered;

  assign rise = src_sync_i & ~src_d_r;
  assign fall = ~src_sync_i & src_d_r;
  assign edge_evt = msg_sel_i ? msg_evt_i : (mode_i == ccp_pkg::MODE_CAP_FALL ? fall : rise);
  assign pwm_mode = mode_i[3:2] == ccp_pkg::MODE_PWM_TOP;
  assign is_cmp = mode_i == ccp_pkg::MODE_CMP_TOGGLE || (mode_i[3] && !pwm_mode);
  assign match = is_cmp && timer_i == data_r;
  assign entered = mode_i != mode_d_r;
  assign duty = {data_r[7:0], duty_low_bits_i};

  always_comb begin
    cap_evt = 1'b0;
    case (mode_i)
      ccp_pkg::MODE_CAP_FALL: cap_evt = edge_evt;
      ccp_pkg::MODE_CAP_RISE: cap_evt = edge_evt;
      ccp_pkg::MODE_CAP_RISE4: cap_evt = edge_evt && pre_r == 4'(ccp_pkg::PRESCALE_4 - 1);
      ccp_pkg::MODE_CAP_RISE16: cap_evt = edge_evt && pre_r == 4'(ccp_pkg::PRESCALE_16 - 1);
      default: cap_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_d_r <= 1'b0;
      mode_d_r <= 4'h0;
    end else begin
      src_d_r <= src_sync_i;
      mode_d_r <= mode_i;
    end
  end

  // Prescaler restarts on any mode change
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_r <= 4'h0;
    end else if (mode_i == ccp_pkg::MODE_OFF || entered) begin
      pre_r <= 4'h0;
    end else if (cap_evt) begin
      pre_r <= 4'h0;
    end else if (edge_evt) begin
      pre_r <= pre_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_r <= '0;
    end else if (cap_evt) begin
      data_r <= timer_i;
    end else if (data_we_i) begin
      data_r <= data_wr_i;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r <= 1'b0;
    end else if (cap_evt || match) begin
      flag_r <= 1'b1;
    end else if (flag_clr_i) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
      trig_r <= 1'b0;
    end else begin
      trig_r <= match && mode_i == ccp_pkg::MODE_CMP_TRIG;
      pin_oe_r <= is_cmp && mode_i != ccp_pkg::MODE_CMP_SOFT && mode_i != ccp_pkg::MODE_CMP_TRIG
                  || pwm_mode;
      case (mode_i)
        ccp_pkg::MODE_CMP_TOGGLE: pin_r <= match ? ~pin_r : pin_r;
        ccp_pkg::MODE_CMP_SET_HI: pin_r <= entered ? 1'b0 : (match ? 1'b1 : pin_r);
        ccp_pkg::MODE_CMP_SET_LO: pin_r <= entered ? 1'b1 : (match ? 1'b0 : pin_r);
        default: pin_r <= pwm_mode ? (pwm_cnt_i < duty) : 1'b0;
      endcase
    end
  end

  assign data_o = data_r;
  assign flag_o = flag_r;
  assign pin_o = pin_r;
  assign pin_oe_o = pin_oe_r;
  assign trig_o = trig_r;

endmodule // ccp_channel

// *** src/capture_compare_pwm_unit.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Four identical capture compare PWM channels
// - One 16-bit data register per channel
// - PWM mode 11xx, duty low bits ctrl[5:4]
// - Duty upper eight bits from data low byte
// - Mode zero disables channel and clears prescaler, keeps data and flag
// - Mode 0010 toggles pin, sets flag
// - Mode 0100 captures every falling edge
// - Mode 0101 captures every rising edge
// - Mode 0110 captures every fourth event
// - Mode 0111 captures every sixteenth event
// - Mode 1000 pin low, match forces high
// - Mode 1001 pin high, match forces low
// - Mode 1010 match only sets flag
// - Mode 1011 match resets timer, flag
// - Trigger never starts a conversion
// - Channel zero may capture message events
// - Control bits 31:6 read zero, others r/w
// - Timer chosen by selection register
module capture_compare_pwm_unit #(
  parameter int NUM_CH = ccp_pkg::NUM_CH,
  parameter int TIMER_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [ccp_pkg::ADDR_W+1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Timers and message event
  input wire logic [ccp_pkg::NUM_TIMERS*TIMER_W-1:0] timers_i,
  input wire logic msg_rx_i,
  // Channel pins
  input wire logic [NUM_CH-1:0] channel_pin_i,
  output logic [NUM_CH-1:0] channel_pin_o,
  output logic [NUM_CH-1:0] channel_pin_oe_o,
  // Timer reset triggers, one per timer
  output logic [ccp_pkg::NUM_TIMERS-1:0] timer_reset_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [ccp_pkg::CTRL_W-1:0] ctrl_r [NUM_CH];
  logic [NUM_CH*ccp_pkg::TSEL_W-1:0] timer_select_reg_r;
  logic msg_timestamp_select_r;
  logic [NUM_CH-1:0] pin_s1_r;
  logic [NUM_CH-1:0] pin_s2_r;
  logic msg_s1_r;
  logic msg_s2_r;
  logic msg_d_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic wait_r;
  logic [ccp_pkg::NUM_TIMERS-1:0] trst_r;
  logic [ccp_pkg::PWM_W-1:0] pwm_cnt_r;

  logic [TIMER_W-1:0] ch_data [NUM_CH];
  logic [NUM_CH-1:0] ch_flag;
  logic [NUM_CH-1:0] ch_pin;
  logic [NUM_CH-1:0] ch_oe;
  logic [NUM_CH-1:0] ch_trig;
  logic [NUM_CH-1:0] data_we;
  logic [NUM_CH-1:0] flag_clr;
  logic [ccp_pkg::ADDR_W-1:0] idx;
  logic req;
  logic wr;
  logic msg_evt;

  assign idx = avs_address_i[ccp_pkg::ADDR_W+1:2];
  assign req = (avs_read_i | avs_write_i) & ~ack_r;
  // Writes land only at the edge where waitrequest is sampled low
  assign wr = avs_write_i & ack_r;
  assign msg_evt = msg_s2_r & ~msg_d_r;

  function automatic logic [ccp_pkg::TSEL_W-1:0] tsel_of(input int ch,
      input logic [NUM_CH*ccp_pkg::TSEL_W-1:0] v);
    tsel_of = v[ch*ccp_pkg::TSEL_W +: ccp_pkg::TSEL_W];
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      msg_s1_r <= 1'b0;
      msg_s2_r <= 1'b0;
      msg_d_r <= 1'b0;
    end else begin
      pin_s1_r <= channel_pin_i;
      pin_s2_r <= pin_s1_r;
      msg_s1_r <= msg_rx_i;
      msg_s2_r <= msg_s1_r;
      msg_d_r <= msg_s2_r;
    end
  end

  // Free-running 10-bit PWM time base
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_cnt_r <= '0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 10'h001;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctrl_r[c] <= ccp_pkg::CTRL_RESET[ccp_pkg::CTRL_W-1:0];
      end
      timer_select_reg_r <= '0;
      msg_timestamp_select_r <= 1'b0;
    end else if (wr && avs_byteenable_i[0]) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (idx == ccp_pkg::CTRL_BASE_IDX + 4'(2 * c)) begin
          ctrl_r[c] <= avs_writedata_i[ccp_pkg::CTRL_W-1:0];
        end
      end
      if (idx == ccp_pkg::TSEL_IDX) begin
        timer_select_reg_r <= avs_writedata_i[NUM_CH*ccp_pkg::TSEL_W-1:0];
      end
      if (idx == ccp_pkg::MSGSEL_IDX) begin
        msg_timestamp_select_r <= avs_writedata_i[0];
      end
    end
  end

  always_comb begin
    data_we = '0;
    flag_clr = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      data_we[c] = wr && idx == ccp_pkg::CTRL_BASE_IDX + 4'(2 * c + 1);
      // Write one to clear
      flag_clr[c] = wr && idx == ccp_pkg::FLAG_IDX && avs_writedata_i[c];
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  // four identical channels
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    ccp_channel #(
      .TIMER_W(TIMER_W)
    ) u_ch (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .mode_i(ctrl_r[g][ccp_pkg::MODE_LSB +: ccp_pkg::MODE_W]),
      .duty_low_bits_i(ctrl_r[g][ccp_pkg::DUTY_LOW_LSB +: ccp_pkg::DUTY_LOW_W]),
      .data_wr_i(avs_writedata_i[TIMER_W-1:0]),
      .data_we_i(data_we[g]),
      .flag_clr_i(flag_clr[g]),
      .src_sync_i(pin_s2_r[g]),
      .msg_sel_i(g == 0 ? msg_timestamp_select_r : 1'b0),
      .msg_evt_i(msg_evt),
      .timer_i(timers_i[tsel_of(g, timer_select_reg_r)*TIMER_W +: TIMER_W]),
      .pwm_cnt_i(pwm_cnt_r),
      .data_o(ch_data[g]),
      .flag_o(ch_flag[g]),
      .pin_o(ch_pin[g]),
      .pin_oe_o(ch_oe[g]),
      .trig_o(ch_trig[g])
    );
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trst_r <= '0;
    end else begin
      for (int t = 0; t < ccp_pkg::NUM_TIMERS; t++) begin
        trst_r[t] <= 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
          if (ch_trig[c] && int'(tsel_of(c, timer_select_reg_r)) == t) begin
            trst_r[t] <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Read path, one wait cycle
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= '0;
    end else begin
      ack_r <= req;
      // Kept as its own flop so the port comes straight from a register
      wait_r <= ~req;
      rdata_r <= '0;
      if (req && avs_read_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (idx == ccp_pkg::CTRL_BASE_IDX + 4'(2 * c)) begin
            rdata_r <= {26'h0, ctrl_r[c]};
          end
          if (idx == ccp_pkg::CTRL_BASE_IDX + 4'(2 * c + 1)) begin
            rdata_r <= {16'h0, ch_data[c]};
          end
        end
        if (idx == ccp_pkg::TSEL_IDX) begin
          rdata_r <= {24'h0, timer_select_reg_r};
        end
        if (idx == ccp_pkg::FLAG_IDX) begin
          rdata_r <= {28'h0, ch_flag};
        end
        if (idx == ccp_pkg::MSGSEL_IDX) begin
          rdata_r <= {31'h0, msg_timestamp_select_r};
        end
      end
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;
  assign channel_pin_o = ch_pin;
  assign channel_pin_oe_o = ch_oe;
  assign timer_reset_o = trst_r;

endmodule // capture_compare_pwm_unit

// *** tb/ccp_checker.sv ***
`timescale 1ns/10ps
// ****
// Bus and channel 0 checks
// ****
module ccp_checker #(
  parameter int NUM_CH = 4,
  parameter int TIMER_W = 16
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [ccp_pkg::ADDR_W+1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [ccp_pkg::NUM_TIMERS*TIMER_W-1:0] timers_i,
  input wire logic msg_rx_i,
  input wire logic [NUM_CH-1:0] channel_pin_i,
  input wire logic [NUM_CH-1:0] channel_pin_o,
  input wire logic [NUM_CH-1:0] channel_pin_oe_o,
  input wire logic [ccp_pkg::NUM_TIMERS-1:0] timer_reset_o
);
  logic [3:0] m_r;
  logic [1:0] sel_r;
  logic [15:0] dat_r;
  logic [1:0] cnt_r;
  logic [3:0] ix;
  logic tk;
  logic mt;
  logic st;
  assign ix = avs_address_i[5:2];
  assign tk = avs_write_i && !avs_waitrequest_o;
  assign mt = timers_i[{sel_r, 4'h0} +: 16] == dat_r;
  assign st = cnt_r == 2'h3;
  // Shadow of channel 0 mode; the count tells how long it has settled
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      m_r <= 4'h0;
      cnt_r <= 2'h3;
    end else if (tk && ix == 4'h0 && avs_byteenable_i[0]) begin
      m_r <= avs_writedata_i[3:0];
      cnt_r <= 2'h0;
    end else if (cnt_r != 2'h3) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_r <= 2'h0;
      dat_r <= 16'h0;
    end else if (tk && ix == 4'h8 && avs_byteenable_i[0]) begin
      sel_r <= avs_writedata_i[1:0];
    end else if (tk && ix == 4'h1) begin
      dat_r <= avs_writedata_i[15:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_idle;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("answer held too long");
  property p_unm;
    avs_read_i && !avs_waitrequest_o && ix > 4'ha |-> avs_readdata_o == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_ctl;
    avs_read_i && !avs_waitrequest_o && ix < 4'h8 && !ix[0] |-> avs_readdata_o[31:6] == 26'h0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control upper bits set");
  property p_oe;
    st |-> channel_pin_oe_o[0] == (m_r inside {4'h2, 4'h8, 4'h9} || m_r[3:2] == 2'h3);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong for mode");
  property p_init;
    cnt_r == 2'h2 && m_r inside {4'h8, 4'h9} |-> channel_pin_o[0] == m_r[0];
  endproperty
  a_init: assert property (p_init) else $error("pin not set on entry");
  property p_hi;
    st && m_r == 4'h8 && mt |=> channel_pin_o[0];
  endproperty
  a_hi: assert property (p_hi) else $error("match did not raise pin");
  property p_lo;
    st && m_r == 4'h9 && mt |=> !channel_pin_o[0];
  endproperty
  a_lo: assert property (p_lo) else $error("match did not lower pin");
  property p_tog;
    st && m_r == 4'h2 && mt |=> channel_pin_o[0] != $past(channel_pin_o[0]);
  endproperty
  a_tog: assert property (p_tog) else $error("match did not toggle pin");
  property p_trg;
    st && m_r == 4'hb && mt |-> ##2 timer_reset_o[sel_r];
  endproperty
  a_trg: assert property (p_trg) else $error("no timer reset on match");
  c_cap: cover property (tk && ix == 4'h0 && avs_writedata_i[3:2] == 2'h1);
  c_trg: cover property (timer_reset_o != 4'h0);
  c_pwm: cover property (st && m_r[3:2] == 2'h3 && channel_pin_o[0]);
endmodule // ccp_checker

// *** tb/ccp_far_model.sv ***
`timescale 1ns/10ps
// ****
// Four timers at the far side
// ****
module ccp_far_model (
  // Clock, reset and control from the bench
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic ld_i,
  input wire logic [15:0] ld_v_i,
  // Trigger in, counts out
  input wire logic [3:0] timer_reset_i,
  output logic [63:0] timers_o
);
  // Loads are spread per timer so a wrong timer choice shows
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timers_o <= 64'h0;
    end else begin
      for (int t = 0; t < 4; t++) begin
        if (timer_reset_i[t]) timers_o[16*t +: 16] <= 16'h0;
        else if (ld_i) timers_o[16*t +: 16] <= ld_v_i + 16'h1000 * 16'(t);
        else if (run_i) timers_o[16*t +: 16] <= timers_o[16*t +: 16] + 16'h1;
      end
    end
  end
endmodule // ccp_far_model

// *** tb/capture_compare_pwm_unit_tb.sv ***
`timescale 1ns/10ps
// ****
// Bench
// ****
module capture_compare_pwm_unit_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [5:0] adr = 6'h0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic wreq;
  logic [63:0] tmr;
  logic msg = 1'b0;
  logic [3:0] pin = 4'h0;
  logic [3:0] pin_o;
  logic [3:0] oe;
  logic [3:0] trs;
  logic run = 1'b0;
  logic ld = 1'b0;
  logic [15:0] ldv = 16'h0;
  logic [31:0] v;
  logic p;
  logic [3:0] cm [5] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
  int n_fail = 0;
  int n_checks = 0;
  int k;
  int e;
  always #5 clk_i = ~clk_i;
  capture_compare_pwm_unit uut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .timers_i(tmr), .msg_rx_i(msg),
    .channel_pin_i(pin), .channel_pin_o(pin_o), .channel_pin_oe_o(oe), .timer_reset_o(trs));
  ccp_far_model fm (.clk_i(clk_i), .rstn_i(rstn_i), .run_i(run), .ld_i(ld), .ld_v_i(ldv),
    .timer_reset_i(trs), .timers_o(tmr));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] ix, input logic [31:0] d,
      input logic [3:0] b);
    int i;
    @(posedge clk_i);
    adr <= {ix, 2'h0};
    wd <= d;
    be <= b;
    rd_s <= !w;
    wr_s <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wreq === 1'b0) break;
    end
    if (i == 20) begin
      n_fail++;
      stop_test();
    end else begin
      v = rdata;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
    end
  endtask
  task automatic wr(input logic [3:0] ix, input logic [31:0] d);
    bus(1'b1, ix, d, 4'hf);
  endtask
  task automatic rd(input logic [3:0] ix);
    bus(1'b0, ix, 32'h0, 4'hf);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic load(input logic [15:0] x);
    @(posedge clk_i);
    ldv <= x;
    ld <= 1'b1;
    @(posedge clk_i);
    ld <= 1'b0;
  endtask
  // Timer moves between the edges, so rise and fall capture apart
  task automatic pulse(input logic m, input logic [15:0] x);
    load(x);
    if (m) msg <= 1'b1;
    else pin[0] <= 1'b1;
    cyc(6);
    load(x | 16'h8000);
    if (m) msg <= 1'b0;
    else pin[0] <= 1'b0;
    cyc(6);
  endtask
  task automatic presc(input logic [3:0] md, input int n, input logic m);
    wr(4'ha, {31'h0, m});
    wr(4'h0, {28'h0, md});
    pulse(m, 16'h0);
    pulse(m, 16'h0);
    wr(4'h0, 32'h0);
    wr(4'h1, 32'h0);
    wr(4'h0, {28'h0, md});
    for (k = 1; k <= 2 * n; k++) begin
      pulse(m, k[15:0]);
      rd(4'h1);
      e = n * (k / n);
      if (md == 4'h4) e = e | 32'h8000;
      chk(v, 32'(e));
    end
    rd(4'h9);
    chk(v[0], 1'b1);
    wr(4'h9, 32'h1);
    rd(4'h9);
    chk(v[0], 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (k = 0; k < 11; k++) begin
      rd(4'(k));
      chk(v, 32'h0);
    end
    for (k = 0; k < 4; k++) begin
      wr(4'(2*k), ~32'(k));
      wr(4'(2*k+1), 32'hffffa5a0 + 32'(k));
      rd(4'(2*k));
      chk(v, 32'h3f & ~32'(k));
      rd(4'(2*k+1));
      chk(v, 32'ha5a0 + 32'(k));
      wr(4'(2*k), 32'h0);
    end
    bus(1'b1, 4'h0, 32'h3, 4'h0);
    rd(4'h0);
    chk(v, 32'h0);
    wr(4'hc, 32'hff);
    rd(4'hc);
    chk(v, 32'h0);
    presc(4'h4, 1, 1'b0);
    presc(4'h5, 1, 1'b0);
    presc(4'h6, 4, 1'b0);
    presc(4'h7, 16, 1'b0);
    presc(4'h6, 4, 1'b1);
    presc(4'h7, 16, 1'b1);
    wr(4'ha, 32'h0);
    wr(4'h8, 32'h1);
    for (k = 0; k < 5; k++) begin
      run <= 1'b0;
      load(16'h0);
      wr(4'h1, 32'h1040);
      wr(4'h0, {28'h0, cm[k]});
      wr(4'h9, 32'h1);
      cyc(4);
      p = pin_o[0];
      if (cm[k] == 4'h8 || cm[k] == 4'h9) chk(pin_o[0], cm[k][0]);
      chk(oe[0], cm[k] < 4'ha);
      run <= 1'b1;
      cyc(100);
      run <= 1'b0;
      rd(4'h9);
      chk(v[0], 1'b1);
      chk(tmr[31:16] < 16'h1040, cm[k] == 4'hb);
      if (cm[k] < 4'ha) chk(pin_o[0], cm[k] == 4'h2 ? !p : cm[k] == 4'h8);
    end
    wr(4'h8, 32'h0);
    for (k = 0; k < 2; k++) begin
      wr(4'h1, k ? 32'h3 : 32'hff40);
      wr(4'h0, k ? 32'h3f : 32'h1c);
      cyc(1100);
      e = 0;
      for (int j = 0; j < 1024; j++) begin
        @(posedge clk_i);
        e += pin_o[0];
      end
      chk(32'(e), k ? 32'hf : 32'h101);
    end
    stop_test();
  end
endmodule // capture_compare_pwm_unit_tb
bind capture_compare_pwm_unit ccp_checker #(.NUM_CH(NUM_CH), .TIMER_W(TIMER_W)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .timers_i(timers_i), .msg_rx_i(msg_rx_i),
  .channel_pin_i(channel_pin_i), .channel_pin_o(channel_pin_o),
  .channel_pin_oe_o(channel_pin_oe_o), .timer_reset_o(timer_reset_o));
